// ===== floppy_command_decoder.sv
// Command acceptance, decode, busy and completion interrupt control
//
// Behaviour
// - Eleven commands in four types are told apart by the upper bits.
// - Forced interrupt is accepted even while busy and aborts the command.
// - Busy stays set for the whole time a command executes.
// - Completion raises the interrupt request and clears busy.
// - After completion the status shows error or clean finish.
// - Type I codes: restore, seek, step, step-in, step-out; flags low.
// - 100 is read sector, 101 write sector, with their flag bits.
// - 1100 read address, 1110 read track, 1111 write track.
// - 1101 is forced interrupt; low four bits select conditions.
// - Variant: bit 1 of type II/III sets the side select output.
// - Type I bits 1 and 0 pick one of four step rates.
// - Type I bit 2 asks for track verify on the destination.
// - Type I bit 3 loads the head at start, else unloads it.
// - Step commands update the track register only when bit 4 set.
// - Write sector bit 0 picks mark FB or deleted mark F8.
// - Base models: type II bit 1 enables side compare.
// - Base models: type II bit 3 is the expected side.
// - Variant: type II bit 3 picks the sector length table.
// - Type II bit 4 selects single or multiple sector transfer.
// - Force conditions: ready rise, ready fall, index, immediate; none.
// - A new command clears the interrupt request; a status read clears it too, except after an immediate forced interrupt.
// - Verify adds 15 ms of head settling after the final step.
module floppy_command_decoder import floppy_cmd_pkg::*; #(
	parameter bit SIDE_SELECT_VARIANT = 1'b0,
	parameter int SETTLE_CYCLES = SETTLE_CYCLES_DFLT
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic cmd_write,
	input wire logic [7:0] cmd_data,
	input wire logic status_read,
	input wire logic ready_in,
	input wire logic index_in,
	input wire logic last_step_done,
	input wire logic exec_done,
	input wire logic exec_error,
	input wire logic [1:0] id_length_code,
	output cmd_s cmd,
	output logic busy,
	output logic cmd_error,
	output logic interrupt_request,
	output logic cmd_go,
	output logic verify_go,
	output logic cmd_abort,
	output logic settling,
	output logic side_select_output,
	output logic head_load_req,
	output logic track_update_en,
	output logic [7:0] data_mark,
	output logic [10:0] sector_bytes
);
	seq_state_e state;
	seq_state_e next_state;
	cmd_s word_fields;
	logic settle_done;
	logic ready_q;
	logic index_q;
	logic arm_rdy;
	logic arm_nrdy;
	logic arm_index;
	logic irq_hold;

	command_field_decode #(
		.SIDE_SELECT_VARIANT(SIDE_SELECT_VARIANT)
	) u_decode (
		.word(cmd_data),
		.fields(word_fields)
	);

	// Acceptance: only a forced interrupt gets in while busy
	wire new_is_force = (word_fields.ctype == TYPE_IV);
	wire new_is_t23 = (word_fields.ctype == TYPE_II) |
		(word_fields.ctype == TYPE_III);
	wire accept = cmd_write & (~busy | new_is_force);
	wire accept_force = accept & new_is_force;
	// Disk commands against a drive that is not ready finish at once
	wire reject = accept & new_is_t23 & ~ready_in;
	wire accept_run = accept & ~new_is_force & ~reject;

	wire in_idle = (state == ST_IDLE);
	wire in_settle = (state == ST_SETTLE);
	wire in_run = (state == ST_RUN);
	wire in_vsettle = (state == ST_VSETTLE);
	wire cur_t1 = (cmd.ctype == TYPE_I);

	// Verify settle only after the last step of a type I command
	wire to_vsettle = in_run & ~exec_done & last_step_done &
		cur_t1 & cmd.verify;
	wire to_settle = in_idle & accept_run &
		word_fields.settle_delay;
	wire settle_start = to_settle | to_vsettle;
	wire completion = in_run & exec_done & ~accept_force;

	settle_timer #(
		.CYCLES(SETTLE_CYCLES)
	) u_settle (
		.mclk(mclk),
		.reset_n(reset_n),
		.start(settle_start),
		.cancel(accept_force),
		.done(settle_done)
	);

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (accept_run) begin
					next_state = word_fields.settle_delay ?
						ST_SETTLE : ST_RUN;
				end
			end
			ST_SETTLE: begin
				if (settle_done) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (exec_done) begin
					next_state = ST_IDLE;
				end else if (to_vsettle) begin
					next_state = ST_VSETTLE;
				end
			end
			ST_VSETTLE: begin
				if (settle_done) begin
					next_state = ST_RUN;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		if (accept_force) begin
			next_state = ST_IDLE;
		end
	end

	// Busy covers settle, run and verify settle alike
	assign busy = ~in_idle;
	assign settling = in_settle | in_vsettle;

	// Forced interrupt conditions, edges of synchronous inputs
	wire ready_rise = ready_in & ~ready_q;
	wire ready_fall = ~ready_in & ready_q;
	wire index_rise = index_in & ~index_q;
	wire cond_hit = (arm_rdy & ready_rise) | (arm_nrdy & ready_fall) |
		(arm_index & index_rise);
	wire irq_set = completion | reject | cond_hit |
		(accept_force & word_fields.irq_immediate);
	// Immediate interrupt survives status reads until the next command
	wire irq_clr = accept | (status_read & ~irq_hold);
	wire next_irq = irq_set | (interrupt_request & ~irq_clr);

	wire go_now = (in_idle & accept_run & ~word_fields.settle_delay) |
		(in_settle & settle_done & ~accept_force);
	wire [10:0] next_sector_bytes =
		(id_length_code == 2'h0) ? (cmd.sector_len_flag ? BYTES_128 :
			BYTES_256) :
		(id_length_code == 2'h1) ? (cmd.sector_len_flag ? BYTES_256 :
			BYTES_512) :
		(id_length_code == 2'h2) ? (cmd.sector_len_flag ? BYTES_512 :
			BYTES_1024) :
		(cmd.sector_len_flag ? BYTES_1024 : BYTES_128);
	wire next_track_upd = (word_fields.code == CMD_SEEK) |
		(word_fields.code == CMD_RESTORE) |
		word_fields.track_update;
	wire [7:0] next_mark = word_fields.deleted_mark_sel ?
		MARK_DELETED : MARK_NORMAL;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state <= ST_IDLE;
			ready_q <= 1'b0;
			index_q <= 1'b0;
		end else begin
			state <= next_state;
			ready_q <= ready_in;
			index_q <= index_in;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cmd <= '0;
			track_update_en <= 1'b0;
			data_mark <= MARK_NORMAL;
		end else if (accept) begin
			cmd <= word_fields;
			track_update_en <= next_track_upd;
			data_mark <= next_mark;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			interrupt_request <= 1'b0;
			irq_hold <= 1'b0;
		end else begin
			interrupt_request <= next_irq;
			if (accept) begin
				irq_hold <= accept_force & word_fields.irq_immediate;
			end
		end
	end

	// A new command disarms old conditions; none armed means no interrupt
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			arm_rdy <= 1'b0;
			arm_nrdy <= 1'b0;
			arm_index <= 1'b0;
		end else if (accept) begin
			arm_rdy <= word_fields.irq_on_becoming_ready;
			arm_nrdy <= word_fields.irq_on_losing_ready;
			arm_index <= word_fields.irq_on_index;
		end
	end

	// Error flag is loaded with the refusal at acceptance, then with the result of the finished command
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cmd_error <= 1'b0;
		end else if (accept) begin
			cmd_error <= reject;
		end else if (completion) begin
			cmd_error <= exec_error;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cmd_go <= 1'b0;
			verify_go <= 1'b0;
			cmd_abort <= 1'b0;
		end else begin
			cmd_go <= go_now;
			verify_go <= in_vsettle & settle_done &
				~accept_force;
			cmd_abort <= accept_force & busy;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			side_select_output <= 1'b0;
		end else if (accept & word_fields.side_select_upd) begin
			side_select_output <= word_fields.side_select_val;
		end
	end

	// Head load follows h at type I start, set for any disk command
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			head_load_req <= 1'b0;
		end else if (accept & ~new_is_force) begin
			head_load_req <= new_is_t23 |
				word_fields.head_load;
		end else if (to_vsettle) begin
			head_load_req <= 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sector_bytes <= BYTES_128;
		end else begin
			sector_bytes <= next_sector_bytes;
		end
	end
endmodule // floppy_command_decoder

// ===== floppy_cmd_pkg.sv
// Shared constants, encodings and carrier types for the command decoder
package floppy_cmd_pkg;

	localparam int CLK_HZ = 10_000_000;
	localparam int SETTLE_MS = 15;
	localparam int SETTLE_CYCLES_DFLT = SETTLE_MS * (CLK_HZ / 1000);
	localparam int SETTLE_CNT_W = 18;

	// Opcode patterns in the upper command bits
	localparam logic [3:0] OP_RESTORE = 4'h0;
	localparam logic [3:0] OP_SEEK = 4'h1;
	localparam logic [2:0] OP3_STEP = 3'h1;
	localparam logic [2:0] OP3_STEP_IN = 3'h2;
	localparam logic [2:0] OP3_STEP_OUT = 3'h3;
	localparam logic [2:0] OP3_RD_SECTOR = 3'h4;
	localparam logic [2:0] OP3_WR_SECTOR = 3'h5;
	localparam logic [3:0] OP_RD_ADDR = 4'hC;
	localparam logic [3:0] OP_FORCE_IRQ = 4'hD;
	localparam logic [3:0] OP_RD_TRACK = 4'hE;
	localparam logic [3:0] OP_WR_TRACK = 4'hF;

	// Field positions in the command word
	localparam int B_RATE_LO = 0;
	localparam int B_RATE_HI = 1;
	localparam int B_VERIFY = 2;
	localparam int B_HEAD_LOAD = 3;
	localparam int B_TRACK_UPD = 4;
	localparam int B_MARK_SEL = 0;
	localparam int B_SIDE_BIT = 1;
	localparam int B_SETTLE = 2;
	localparam int B_SIDE_LEN = 3;
	localparam int B_MULTI = 4;
	localparam int B_IRQ_RDY = 0;
	localparam int B_IRQ_NRDY = 1;
	localparam int B_IRQ_INDEX = 2;
	localparam int B_IRQ_IMM = 3;

	localparam logic [7:0] MARK_NORMAL = 8'hFB;
	localparam logic [7:0] MARK_DELETED = 8'hF8;

	localparam logic [10:0] BYTES_128 = 11'h080;
	localparam logic [10:0] BYTES_256 = 11'h100;
	localparam logic [10:0] BYTES_512 = 11'h200;
	localparam logic [10:0] BYTES_1024 = 11'h400;

	typedef enum logic [3:0] {
		CMD_RESTORE = 4'h0, CMD_SEEK = 4'h1, CMD_STEP = 4'h2,
		CMD_STEP_IN = 4'h3, CMD_STEP_OUT = 4'h4, CMD_RD_SECTOR = 4'h5,
		CMD_WR_SECTOR = 4'h6, CMD_RD_ADDR = 4'h7, CMD_RD_TRACK = 4'h8,
		CMD_WR_TRACK = 4'h9, CMD_FORCE_IRQ = 4'hA
	} cmd_code_e;

	typedef enum logic [1:0] {
		TYPE_I = 2'h0, TYPE_II = 2'h1, TYPE_III = 2'h2, TYPE_IV = 2'h3
	} cmd_type_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0, ST_SETTLE = 2'h1, ST_RUN = 2'h3, ST_VSETTLE = 2'h2
	} seq_state_e;

	typedef struct packed {
		cmd_code_e code;
		cmd_type_e ctype;
		logic rate_sel_hi;
		logic rate_sel_lo;
		logic verify;
		logic head_load;
		logic track_update;
		logic multi_record;
		logic settle_delay;
		logic side_compare_en;
		logic expected_side;
		logic sector_len_flag;
		logic side_select_upd;
		logic side_select_val;
		logic deleted_mark_sel;
		logic irq_on_becoming_ready;
		logic irq_on_losing_ready;
		logic irq_on_index;
		logic irq_immediate;
	} cmd_s;

endpackage

// ===== command_field_decode.sv
// Combinational split of a command word into command code and flags
module command_field_decode import floppy_cmd_pkg::*; #(
	parameter bit SIDE_SELECT_VARIANT = 1'b0
) (
	input wire logic [7:0] word,
	output cmd_s fields
);
	wire [3:0] hi = word[7:4];
	wire [2:0] hi3 = word[7:5];
	wire is_rd_sec = (hi3 == OP3_RD_SECTOR);
	wire is_wr_sec = (hi3 == OP3_WR_SECTOR);
	wire is_force = (hi == OP_FORCE_IRQ);
	wire is_t1 = ~word[7];
	wire is_t2 = is_rd_sec | is_wr_sec;
	wire is_t3 = word[7] & ~is_t2 & ~is_force;
	wire is_step = (hi3 == OP3_STEP) | (hi3 == OP3_STEP_IN) |
		(hi3 == OP3_STEP_OUT);

	// Eleven codes in four types from the upper bits
	wire cmd_code_e code =
		(hi == OP_RESTORE) ? CMD_RESTORE :
		(hi == OP_SEEK) ? CMD_SEEK :
		(hi3 == OP3_STEP) ? CMD_STEP :
		(hi3 == OP3_STEP_IN) ? CMD_STEP_IN :
		(hi3 == OP3_STEP_OUT) ? CMD_STEP_OUT :
		is_rd_sec ? CMD_RD_SECTOR :
		is_wr_sec ? CMD_WR_SECTOR :
		(hi == OP_RD_ADDR) ? CMD_RD_ADDR :
		(hi == OP_RD_TRACK) ? CMD_RD_TRACK :
		(hi == OP_WR_TRACK) ? CMD_WR_TRACK :
		CMD_FORCE_IRQ;
	wire cmd_type_e ctype = is_t1 ? TYPE_I : is_t2 ? TYPE_II :
		is_t3 ? TYPE_III : TYPE_IV;
	wire side_bit = word[B_SIDE_BIT] & (is_t2 | is_t3);

	assign fields.code = code;
	assign fields.ctype = ctype;
	assign fields.rate_sel_hi = is_t1 & word[B_RATE_HI];
	assign fields.rate_sel_lo = is_t1 & word[B_RATE_LO];
	assign fields.verify = is_t1 & word[B_VERIFY];
	assign fields.head_load = is_t1 & word[B_HEAD_LOAD];
	assign fields.track_update = is_step & word[B_TRACK_UPD];
	assign fields.multi_record = is_t2 & word[B_MULTI];
	assign fields.settle_delay = (is_t2 | is_t3) & word[B_SETTLE];
	// Variant choice is static, bit 1 and bit 3 swap meaning
	assign fields.side_compare_en = ~SIDE_SELECT_VARIANT & is_t2 &
		word[B_SIDE_BIT];
	assign fields.expected_side = ~SIDE_SELECT_VARIANT & is_t2 &
		word[B_SIDE_LEN];
	assign fields.sector_len_flag = SIDE_SELECT_VARIANT & is_t2 &
		word[B_SIDE_LEN];
	assign fields.side_select_upd = SIDE_SELECT_VARIANT & (is_t2 | is_t3);
	assign fields.side_select_val = SIDE_SELECT_VARIANT & side_bit;
	assign fields.deleted_mark_sel = is_wr_sec & word[B_MARK_SEL];
	assign fields.irq_on_becoming_ready = is_force & word[B_IRQ_RDY];
	assign fields.irq_on_losing_ready = is_force & word[B_IRQ_NRDY];
	assign fields.irq_on_index = is_force & word[B_IRQ_INDEX];
	assign fields.irq_immediate = is_force & word[B_IRQ_IMM];
endmodule // command_field_decode

// ===== settle_timer.sv
// Head settling delay counter, one done pulse per start unless cancel comes first
module settle_timer import floppy_cmd_pkg::*; #(
	parameter int CYCLES = SETTLE_CYCLES_DFLT
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic start,
	input wire logic cancel,
	output logic done
);
	// Start and done each cost a cycle, so the count stops two short
	localparam logic [SETTLE_CNT_W-1:0] LAST =
		SETTLE_CNT_W'(CYCLES - 2);
	logic [SETTLE_CNT_W-1:0] count;
	logic running;
	wire at_last = running & (count == LAST);

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			count <= '0;
			running <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= at_last & ~cancel;
			running <= start | (running & ~at_last & ~cancel);
			count <= (start | ~running) ? '0 : count + 1'b1;
		end
	end
endmodule // settle_timer

// ===== floppy_command_decoder_checker.sv
// Port-level assertions for the floppy command decoder
module floppy_command_decoder_checker import floppy_cmd_pkg::*; #(
	parameter bit SIDE_SELECT_VARIANT = 1'b0,
	parameter int SETTLE_CYCLES = SETTLE_CYCLES_DFLT
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic cmd_write,
	input wire logic [7:0] cmd_data,
	input wire logic status_read,
	input wire logic ready_in,
	input wire logic exec_done,
	input wire logic exec_error,
	input wire cmd_s cmd,
	input wire logic busy,
	input wire logic cmd_error,
	input wire logic interrupt_request,
	input wire logic cmd_go,
	input wire logic verify_go,
	input wire logic cmd_abort,
	input wire logic settling,
	input wire logic [7:0] data_mark
);
	logic taken;
	logic is_force;
	logic forced;
	logic perr;
	logic [7:0] pw;
	logic [31:0] scnt;
	assign is_force = cmd_data[7:4] == OP_FORCE_IRQ;
	assign taken = cmd_write && (!busy || is_force);
	// Held force conditions may legally keep the request up over reads
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			scnt <= '0;
			forced <= 1'b0;
			pw <= 8'h00;
			perr <= 1'b0;
		end else begin
			scnt <= settling ? scnt + 1 : '0;
			pw <= cmd_data;
			perr <= exec_error;
			if (taken)
				forced <= is_force;
		end
	end
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);
	AST_BUSY_HOLD: assert property (
		busy && !exec_done && !(cmd_write && is_force) |=> busy)
		else $error("busy dropped without completion");
	AST_DONE: assert property (
		busy && !settling && exec_done && !cmd_write
		|=> !busy && interrupt_request && cmd_error == perr)
		else $error("completion did not end cleanly");
	AST_TYPE1_FLAGS: assert property (
		taken && !cmd_data[7] |=> {cmd.rate_sel_hi, cmd.rate_sel_lo,
		cmd.verify, cmd.head_load} == {pw[1:0], pw[2], pw[3]})
		else $error("type one flags wrong");
	AST_MARK: assert property (
		taken && cmd_data[7:5] == OP3_WR_SECTOR && ready_in
		|=> data_mark == (pw[0] ? MARK_DELETED : MARK_NORMAL))
		else $error("data mark wrong");
	AST_NOT_READY: assert property (
		taken && cmd_data[7] && !is_force && !ready_in
		|=> !busy && interrupt_request && cmd_error)
		else $error("not ready command not refused");
	AST_ABORT: assert property (
		cmd_write && is_force && busy |=> cmd_abort && !busy && !settling)
		else $error("forced interrupt did not abort");
	AST_IMMEDIATE: assert property (
		taken && is_force && cmd_data[3] |=> interrupt_request[*2])
		else $error("immediate interrupt missing");
	AST_WRITE_CLR: assert property (
		taken && !cmd_data[7] |=> !interrupt_request)
		else $error("command write left request up");
	AST_READ_CLR: assert property (
		status_read && !forced && !busy && !cmd_write
		|=> !interrupt_request)
		else $error("status read left request up");
	AST_SETTLE_LEN: assert property (
		$fell(settling) && busy
		|-> (cmd_go || verify_go) && scnt == SETTLE_CYCLES)
		else $error("settle length wrong");
endmodule // floppy_command_decoder_checker

bind floppy_command_decoder floppy_command_decoder_checker #(
	.SIDE_SELECT_VARIANT(SIDE_SELECT_VARIANT),
	.SETTLE_CYCLES(SETTLE_CYCLES)
) u_checker (.mclk, .reset_n, .cmd_write, .cmd_data, .status_read,
	.ready_in, .exec_done, .exec_error, .cmd, .busy, .cmd_error,
	.interrupt_request, .cmd_go, .verify_go, .cmd_abort, .settling,
	.data_mark);

// ===== host_model.sv
// Host processor model: command writes and status reads
module host_model (
	input wire logic mclk,
	input wire logic busy,
	output logic cmd_write,
	output logic [7:0] cmd_data,
	output logic status_read
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		cmd_write = 1'b0;
		cmd_data = 8'h00;
		status_read = 1'b0;
	end
	// Entered at a falling edge; leaves one idle cycle behind
	task automatic write_cmd(input logic [7:0] w);
		int n;
		n = 0;
		while (busy !== 1'b0 && w[7:4] != 4'hD && n < 5000) begin
			@(negedge mclk);
			n++;
		end
		cmd_write <= 1'b1;
		cmd_data <= w;
		@(negedge mclk);
		cmd_write <= 1'b0;
		cmd_data <= ~w;
		@(negedge mclk);
	endtask
	task automatic read_status();
		status_read <= 1'b1;
		@(negedge mclk);
		status_read <= 1'b0;
		@(negedge mclk);
	endtask
endmodule // host_model

// ===== floppy_command_decoder_tb.sv
// Self-checking bench for the floppy command decoder
module floppy_command_decoder_tb import floppy_cmd_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int SETTLE = 20;
	logic mclk, reset_n, ready_in, index_in, last_step_done;
	logic exec_done, exec_error, err_lvl;
	logic irq_prev = 1'b0;
	bit vphase = 1'b0;
	logic cmd_write, status_read, busy, cmd_error, interrupt_request;
	logic cmd_go, verify_go, cmd_abort, settling;
	logic side_select_output, head_load_req, track_update_en;
	logic [1:0] id_length_code;
	logic [7:0] cmd_data, data_mark, w;
	logic [10:0] sector_bytes;
	cmd_s cmd;
	int n_fail, checks;
	int cnt = 0;
	logic [55:0] notes[$];
	// Forced interrupt request: code, type and a clean finish
	localparam logic [55:0] FORCE_NOTE =
		{28'h0FE0000, 4'h0, CMD_FORCE_IRQ, TYPE_IV, 18'h0};
	floppy_command_decoder #(.SETTLE_CYCLES(SETTLE)) u_floppy_command_decoder (
		.mclk, .reset_n, .cmd_write, .cmd_data, .status_read, .ready_in,
		.index_in, .last_step_done, .exec_done, .exec_error,
		.id_length_code, .cmd, .busy, .cmd_error, .interrupt_request,
		.cmd_go, .verify_go, .cmd_abort, .settling,
		.side_select_output, .head_load_req, .track_update_en,
		.data_mark, .sector_bytes);
	host_model u_host_model (.mclk, .busy, .cmd_write, .cmd_data,
		.status_read);
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	// Expected {mask, value} over pins, code, type, error, mark and flags
	function automatic logic [55:0] expect_of(logic [7:0] w, logic err);
		logic [27:0] e, m;
		logic step;
		step = !w[7] && w[6:5] != 2'h0;
		e = {8'h00, 2'h0, err, 17'h0};
		m = 28'h0FE0000;
		case (w[7:4])
			4'h0: e[23:20] = CMD_RESTORE;
			4'h1: e[23:20] = CMD_SEEK;
			4'h2, 4'h3: e[23:20] = CMD_STEP;
			4'h4, 4'h5: e[23:20] = CMD_STEP_IN;
			4'h6, 4'h7: e[23:20] = CMD_STEP_OUT;
			4'h8, 4'h9: e[23:20] = CMD_RD_SECTOR;
			4'hA, 4'hB: e[23:20] = CMD_WR_SECTOR;
			4'hC: e[23:20] = CMD_RD_ADDR;
			4'hE: e[23:20] = CMD_RD_TRACK;
			default: e[23:20] = CMD_WR_TRACK;
		endcase
		e[19:18] = !w[7] ? TYPE_I : (!w[6] ? TYPE_II : TYPE_III);
		if (!w[7]) begin
			e[4:0] = {w[4] & step, w[3:0]};
			m[4:0] = {step, 4'hF};
			e[26:25] = {w[3] | w[2], !step | w[4]};
			m[26:25] = 2'h3;
		end else if (!w[6]) begin
			e[8:5] = w[4:1];
			m[8:5] = 4'hF;
			m[16:9] = w[5] ? 8'hFF : 8'h00;
			e[16:9] = w[5] ? (w[0] ? MARK_DELETED : MARK_NORMAL) :
				8'h00;
		end else begin
			e[6] = w[2];
			m[6] = 1'b1;
		end
		if (w[7]) begin
			e[27:26] = 2'h1;
			m[27:26] = 2'h3;
		end
		return {m, e};
	endfunction
	task automatic chk(input logic [55:0] n);
		logic [27:0] o;
		o = {side_select_output, head_load_req, track_update_en, 1'b0,
			cmd.code, cmd.ctype, cmd_error, data_mark, cmd.multi_record,
			cmd.expected_side, cmd.settle_delay, cmd.side_compare_en,
			cmd.track_update, cmd.head_load, cmd.verify, cmd.rate_sel_hi,
			cmd.rate_sel_lo};
		checks++;
		if ((o & n[55:28]) !== n[27:0]) begin
			n_fail++;
			$display("mismatch t=%0t got %h exp %h", $time, o & n[55:28],
				n[27:0]);
		end
	endtask
	// Sector size per length code with the sector length flag clear
	function automatic logic [10:0] len_of(logic [1:0] c);
		case (c)
			2'h0: return BYTES_256;
			2'h1: return BYTES_512;
			2'h2: return BYTES_1024;
			default: return BYTES_128;
		endcase
	endfunction
	task automatic chk_len(input logic [10:0] x);
		checks++;
		if (sector_bytes !== x) begin
			n_fail++;
			$display("mismatch t=%0t got %h exp %h", $time, sector_bytes,
				x);
		end
	endtask
	task automatic issue(input logic [7:0] w, input logic err);
		while (busy !== 1'b0)
			@(negedge mclk);
		err_lvl = err;
		notes.push_back(expect_of(w, err));
		u_host_model.write_cmd(w);
	endtask
	// Each rise of the request retires the oldest note
	always @(negedge mclk) begin
		if (interrupt_request === 1'b1 && irq_prev !== 1'b1)
			chk(notes.size() != 0 ? notes.pop_front() :
				56'h0000000FFFFFFF);
		irq_prev = interrupt_request;
	end
	// Sequencer stand-in: answers go pulses after a random delay
	always @(negedge mclk) begin
		automatic bit fin = cmd_abort !== 1'b1 && cmd_go !== 1'b1 &&
			verify_go !== 1'b1 && cnt == 1;
		exec_done <= fin && !vphase;
		last_step_done <= fin && vphase;
		exec_error <= err_lvl;
		if (cmd_abort === 1'b1) begin
			cnt = 0;
		end else if (cmd_go === 1'b1 || verify_go === 1'b1) begin
			vphase = cmd_go === 1'b1 && cmd.ctype === TYPE_I && cmd.verify;
			cnt = 3 + $urandom % 6;
		end else if (cnt > 0) begin
			cnt--;
		end
	end
	task automatic final_report();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge mclk);
		n_fail++;
		final_report();
	end
	initial begin
		void'($urandom(71));
		{reset_n, index_in} = '0;
		{err_lvl, n_fail, checks} = '0;
		ready_in = 1'b1;
		id_length_code = 2'h0;
		repeat (3) @(posedge mclk);
		@(negedge mclk);
		reset_n = 1'b1;
		for (int h = 0; h < 8; h++)
			issue({4'(h), 4'($urandom)}, 1'($urandom));
		$display("test type one done");
		for (int h = 8; h < 16; h++) begin
			w = {4'(h), 4'($urandom)};
			if (h > 11)
				w = w & 8'hF4;
			if (h != 13)
				issue(w, 1'($urandom));
		end
		while (busy !== 1'b0)
			@(negedge mclk);
		repeat (20) @(negedge mclk);
		u_host_model.read_status();
		for (int i = 0; i < 4; i++) begin
			id_length_code = 2'($urandom);
			@(negedge mclk);
			chk_len(len_of(id_length_code));
		end
		$display("test type two three done");
		ready_in = 1'b0;
		notes.push_back({28'h0020000, 28'h0020000});
		u_host_model.write_cmd(8'hA4);
		ready_in = 1'b1;
		u_host_model.write_cmd(8'h08);
		u_host_model.write_cmd(8'hD0);
		u_host_model.write_cmd(8'hA4);
		u_host_model.write_cmd(8'hD0);
		$display("test abort done");
		notes.push_back(FORCE_NOTE);
		u_host_model.write_cmd(8'hD8);
		u_host_model.read_status();
		u_host_model.write_cmd(8'hD3);
		notes.push_back(FORCE_NOTE);
		ready_in = 1'b0;
		repeat (3) @(negedge mclk);
		u_host_model.read_status();
		notes.push_back(FORCE_NOTE);
		ready_in = 1'b1;
		repeat (3) @(negedge mclk);
		u_host_model.read_status();
		u_host_model.write_cmd(8'hD4);
		notes.push_back(FORCE_NOTE);
		index_in = 1'b1;
		repeat (2) @(negedge mclk);
		index_in = 1'b0;
		repeat (3) @(negedge mclk);
		u_host_model.read_status();
		issue(8'h1F, 1'b0);
		$display("test force conditions done");
		for (int i = 0; i < 300 && notes.size() != 0; i++)
			@(negedge mclk);
		checks++;
		if (notes.size() != 0) begin
			n_fail++;
			$display("mismatch t=%0t got %h exp %h", $time, notes.size(), 0);
		end
		final_report();
	end
endmodule // floppy_command_decoder_tb
